// [logic/pcm_pad_config.v]
// Pad configuration registers and function muxes for pads 4 to 11
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "pcm_consts.vh"
module pcm_pad_config #(
  parameter [31:0] KEY_VALUE = `PCM_KEY_DEFAULT
) (
  // Clock, reset, enable
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_clk_en,
  // AXI4-Lite write address channel
  input wire [11:0] i_axi_awaddr,
  input wire i_axi_awvalid,
  output reg o_axi_awready,
  // AXI4-Lite write data channel
  input wire [31:0] i_axi_wdata,
  input wire [3:0] i_axi_wstrb,
  input wire i_axi_wvalid,
  output reg o_axi_wready,
  // AXI4-Lite write response channel
  output reg [1:0] o_axi_bresp,
  output reg o_axi_bvalid,
  input wire i_axi_bready,
  // AXI4-Lite read address channel
  input wire [11:0] i_axi_araddr,
  input wire i_axi_arvalid,
  output reg o_axi_arready,
  // AXI4-Lite read data channel
  output reg [31:0] o_axi_rdata,
  output reg [1:0] o_axi_rresp,
  output reg o_axi_rvalid,
  input wire i_axi_rready,
  // Peripheral signals, eight functions per pad, pad 4 in the low byte
  input wire [63:0] i_pad_func_out,
  input wire [63:0] i_pad_func_oe,
  output wire [63:0] o_pad_func_in,
  // Pads 4 to 11, pad 4 in bit 0
  input wire [7:0] i_pad_in,
  output wire [7:0] o_pad_out,
  output wire [7:0] o_pad_oe,
  // Pad electrical controls, pad 4 in bit 0
  output reg [7:0] o_pad_drive_high,
  output reg [7:0] o_pad_input_en,
  output reg [7:0] o_pad_pullup_en,
  // Pull-up resistor codes for pads 9, 8, 6, 5 from high to low
  output reg [7:0] o_pullup_resistor_select,
  // Pad 4 switch to ground
  output reg o_pad4_ground_switch_enable
);

  // Map an address onto a register select code
  function [1:0] pcm_reg_sel;
    input [11:0] addr;
    reg [11:0] word;
    begin
      // Low two address bits are ignored
      word = {addr[11:2], 2'b00};
      if (word == `PCM_OFS_GROUP_4_7)
        pcm_reg_sel = `PCM_SEL_GROUP_4_7;
      else if (word == `PCM_OFS_GROUP_8_11)
        pcm_reg_sel = `PCM_SEL_GROUP_8_11;
      else if (word == `PCM_OFS_WRITE_KEY)
        pcm_reg_sel = `PCM_SEL_WRITE_KEY;
      else
        pcm_reg_sel = `PCM_SEL_NONE;
    end
  endfunction

  // Codes that connect nothing on a given pad
  function [7:0] pcm_rsvd_mask;
    input integer pad;
    begin
      // Only pad 5 leaves one code unconnected
      case (pad)
        4: pcm_rsvd_mask = 8'h00;
        5: pcm_rsvd_mask = 8'h20;
        6: pcm_rsvd_mask = 8'h00;
        7: pcm_rsvd_mask = 8'h00;
        8: pcm_rsvd_mask = 8'h00;
        9: pcm_rsvd_mask = 8'h00;
        10: pcm_rsvd_mask = 8'h00;
        11: pcm_rsvd_mask = 8'h00;
        default: pcm_rsvd_mask = 8'h00;
      endcase
    end
  endfunction

  // Pad configuration words
  reg [31:0] pad_config_group_4_7_r;
  reg [31:0] pad_config_group_8_11_r;
  // Held write address and data
  reg aw_held_r;
  reg [11:0] aw_addr_r;
  reg w_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  // Lock state from the key
  wire unlocked;

  // Both halves held and no response pending
  wire wr_fire = aw_held_r & w_held_r & ~o_axi_bvalid;
  wire [1:0] wr_sel = pcm_reg_sel(aw_addr_r);
  // Handshakes on the three request channels
  wire aw_take = i_axi_awvalid & o_axi_awready;
  wire w_take = i_axi_wvalid & o_axi_wready;
  wire ar_take = i_axi_arvalid & o_axi_arready;
  // Register picked by the read address
  wire [1:0] rd_sel = pcm_reg_sel(i_axi_araddr);
  // Byte strobes widened to a bit mask
  wire [31:0] strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                           {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  // Pad write allowed only while unlocked
  wire cfg_wr_ok = wr_fire & unlocked;
  // Both config words side by side, pad 4 in the low byte
  wire [63:0] cfg = {pad_config_group_8_11_r, pad_config_group_4_7_r};

  // Key register
  // Compares the whole data word, byte strobes play no part
  pcm_key_lock #(
    .KEY_VALUE(KEY_VALUE)
  ) u_key (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_wr(wr_fire & (wr_sel == `PCM_SEL_WRITE_KEY)),
    .i_wdata(w_data_r),
    .o_unlocked(unlocked)
  );

  // Write address and data capture, in either order
  // Each half waits until the write fires: one write in flight
  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // Nothing held, both channels ready
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      o_axi_awready <= 1'b1;
      o_axi_wready <= 1'b1;
    end
    else if (i_clk_en)
    begin
      // Address half
      if (aw_take)
      begin
        // Hold the address and refuse another one
        aw_addr_r <= i_axi_awaddr;
        aw_held_r <= 1'b1;
        o_axi_awready <= 1'b0;
      end
      else if (wr_fire)
      begin
        // Write done, address channel open again
        aw_held_r <= 1'b0;
        o_axi_awready <= 1'b1;
      end
      // Data half
      if (w_take)
      begin
        // Hold data and strobes until the write fires
        w_data_r <= i_axi_wdata;
        w_strb_r <= i_axi_wstrb;
        w_held_r <= 1'b1;
        o_axi_wready <= 1'b0;
      end
      else if (wr_fire)
      begin
        // Write done, data channel open again
        w_held_r <= 1'b0;
        o_axi_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // No response pending
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= `PCM_RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (wr_fire)
      begin
        // Both halves present: answer the write
        o_axi_bvalid <= 1'b1;
        // Locked pad writes still answer okay
        o_axi_bresp <= (wr_sel == `PCM_SEL_NONE) ?
                       `PCM_RESP_SLVERR : `PCM_RESP_OKAY;
      end
      else if (i_axi_bready)
      begin
        // Response taken by the master
        o_axi_bvalid <= 1'b0;
      end
    end
  end

  // Pad configuration words, masked by strobes and writable bits
  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // Every selector back to general I/O
      pad_config_group_4_7_r <= `PCM_RST_GROUP_4_7;
      pad_config_group_8_11_r <= `PCM_RST_GROUP_8_11;
    end
    else if (i_clk_en && cfg_wr_ok)
    begin
      // Only unlocked writes to a pad register land here
      // Reserved bits never take a one
      if (wr_sel == `PCM_SEL_GROUP_4_7)
        pad_config_group_4_7_r <=
          (pad_config_group_4_7_r & ~(strb_mask & `PCM_WMASK_GROUP_4_7)) |
          (w_data_r & strb_mask & `PCM_WMASK_GROUP_4_7);
      if (wr_sel == `PCM_SEL_GROUP_8_11)
        pad_config_group_8_11_r <=
          (pad_config_group_8_11_r & ~(strb_mask & `PCM_WMASK_GROUP_8_11)) |
          (w_data_r & strb_mask & `PCM_WMASK_GROUP_8_11);
    end
  end

  // Read channel, one read at a time
  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // Ready for a read, no data pending
      o_axi_arready <= 1'b1;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h0000_0000;
      o_axi_rresp <= `PCM_RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (ar_take)
      begin
        // Answer in the next cycle, refuse further reads
        o_axi_arready <= 1'b0;
        o_axi_rvalid <= 1'b1;
        o_axi_rresp <= `PCM_RESP_OKAY;
        // Current field values, reserved bits zero
        case (rd_sel)
          `PCM_SEL_GROUP_4_7: o_axi_rdata <= pad_config_group_4_7_r;
          `PCM_SEL_GROUP_8_11: o_axi_rdata <= pad_config_group_8_11_r;
          // Key reads back only the lock state
          `PCM_SEL_WRITE_KEY: o_axi_rdata <= {31'h000_0000, unlocked};
          default:
          begin
            // Unmapped address reads zero with an error
            o_axi_rdata <= 32'h0000_0000;
            o_axi_rresp <= `PCM_RESP_SLVERR;
          end
        endcase
      end
      else if (o_axi_rvalid && i_axi_rready)
      begin
        // Data taken, accept the next read
        o_axi_rvalid <= 1'b0;
        o_axi_arready <= 1'b1;
      end
    end
  end

  // Electrical controls from each pad slot
  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin : pcm_elec
    integer k;
    if (i_sys_rst)
    begin
      // Low drive, input and pull-up off on every pad
      o_pad_drive_high <= 8'h00;
      o_pad_input_en <= 8'h00;
      o_pad_pullup_en <= 8'h00;
      o_pullup_resistor_select <= 8'h00;
      o_pad4_ground_switch_enable <= 1'b0;
    end
    else if (i_clk_en)
    begin
      // Same three bits in every pad slot
      for (k = 0; k < 8; k = k + 1)
      begin
        o_pad_drive_high[k] <= cfg[k*8 + `PCM_FLD_DRIVE];
        o_pad_input_en[k] <= cfg[k*8 + `PCM_FLD_INPUT_EN];
        o_pad_pullup_en[k] <= cfg[k*8 + `PCM_FLD_PULLUP];
      end
      // Slots of pads 5, 6, 8, 9 carry a resistor code
      o_pullup_resistor_select <= {cfg[47:46], cfg[39:38],
                                   cfg[23:22], cfg[15:14]};
      o_pad4_ground_switch_enable <= cfg[`PCM_FLD_EXTRA_HI];
    end
  end

  // One function mux per pad
  // Pad p + 4 sits in byte p of the config pair
  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1)
    begin : g_pad
      // Pad 5 leaves its reserved code unconnected
      pcm_pad_mux #(
        .RSVD_MASK(pcm_rsvd_mask(p + 4))
      ) u_mux (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_sel(cfg[p*8+`PCM_FLD_FUNC_HI:p*8+`PCM_FLD_FUNC_LO]),
        .i_in_en(cfg[p*8 + `PCM_FLD_INPUT_EN]),
        .i_func_out(i_pad_func_out[p*8+7:p*8]),
        .i_func_oe(i_pad_func_oe[p*8+7:p*8]),
        .o_func_in(o_pad_func_in[p*8+7:p*8]),
        .i_pad_in(i_pad_in[p]),
        .o_pad_out(o_pad_out[p]),
        .o_pad_oe(o_pad_oe[p])
      );
    end
  endgenerate

endmodule // pcm_pad_config

// [logic/pcm_consts.vh]
// Offsets, field layout, reset values and key code for the pad config mux
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

// Register byte offsets inside the block window
`define PCM_OFS_GROUP_4_7 12'h004
`define PCM_OFS_GROUP_8_11 12'h008
`define PCM_OFS_WRITE_KEY 12'h060

// Register select codes from the address decoder
`define PCM_SEL_NONE 2'h0
`define PCM_SEL_GROUP_4_7 2'h1
`define PCM_SEL_GROUP_8_11 2'h2
`define PCM_SEL_WRITE_KEY 2'h3

// Field positions inside one 8-bit pad slot
`define PCM_FLD_PULLUP 0
`define PCM_FLD_INPUT_EN 1
`define PCM_FLD_DRIVE 2
`define PCM_FLD_FUNC_LO 3
`define PCM_FLD_FUNC_HI 5
`define PCM_FLD_EXTRA_LO 6
`define PCM_FLD_EXTRA_HI 7
`define PCM_SLOT_W 8

// Reset values: every function selector at the general I/O code 0x3
`define PCM_FUNC_GPIO 3'h3
`define PCM_RST_GROUP_4_7 32'h1818_1818
`define PCM_RST_GROUP_8_11 32'h1818_1818

// Writable bits; reserved bits stay zero
`define PCM_WMASK_GROUP_4_7 32'h3FFF_FFBF
`define PCM_WMASK_GROUP_8_11 32'h3F3F_FFFF

// Unlock code for the write key, value is arbitrary
`define PCM_KEY_DEFAULT 32'h0000_0073

// Bus responses
`define PCM_RESP_OKAY 2'h0
`define PCM_RESP_SLVERR 2'h2

`endif

// [logic/pcm_key_lock.v]
// Write key that unlocks the pad configuration registers
`timescale 1ns/1ns
`include "pcm_consts.vh"
module pcm_key_lock #(
  parameter [31:0] KEY_VALUE = `PCM_KEY_DEFAULT
) (
  // Clock, reset, enable
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_clk_en,
  // Key write strobe and data
  input wire i_wr,
  input wire [31:0] i_wdata,
  // Lock state
  output reg o_unlocked
);

  // Matching code unlocks, any other value locks again
  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // Locked after reset
      o_unlocked <= 1'b0;
    end
    else if (i_clk_en && i_wr)
    begin
      o_unlocked <= (i_wdata == KEY_VALUE);
    end
  end

endmodule // pcm_key_lock

// [logic/pcm_pad_mux.v]
// Function select mux for one pad, with registered outputs
`timescale 1ns/1ns
module pcm_pad_mux #(
  parameter [7:0] RSVD_MASK = 8'h00
) (
  // Clock, reset, enable
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_clk_en,
  // Pad controls
  input wire [2:0] i_sel,
  input wire i_in_en,
  // Peripheral side
  input wire [7:0] i_func_out,
  input wire [7:0] i_func_oe,
  output reg [7:0] o_func_in,
  // Pad side
  input wire i_pad_in,
  output reg o_pad_out,
  output reg o_pad_oe
);

  // Selected function is live unless its code is reserved
  wire live = ~RSVD_MASK[i_sel];
  // One-hot of the selected function
  wire [7:0] onehot = 8'h01 << i_sel;

  // Route the selected function both ways
  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // Pad undriven, no input reaches any function
      o_pad_out <= 1'b0;
      o_pad_oe <= 1'b0;
      o_func_in <= 8'h00;
    end
    else if (i_clk_en)
    begin
      o_pad_out <= live & i_func_out[i_sel];
      o_pad_oe <= live & i_func_oe[i_sel];
      // Input disabled pads feed zero to every function
      o_func_in <= (live & i_in_en & i_pad_in) ? onehot : 8'h00;
    end
  end

endmodule // pcm_pad_mux

// [test/pcm_pad_config_asserts.sv]
// Checker for the pad configuration block
`timescale 1ns/1ns
module pcm_pad_config_asserts (
  // Clock, reset, enable
  input logic i_clk_sys,
  input logic i_sys_rst,
  input logic i_clk_en,
  // Read channels
  input logic [11:0] i_axi_araddr,
  input logic i_axi_arvalid,
  input logic o_axi_arready,
  input logic o_axi_rvalid,
  input logic [31:0] o_axi_rdata,
  input logic [1:0] o_axi_rresp,
  // Pad controls
  input logic [63:0] o_pad_func_in,
  input logic [7:0] o_pad_drive_high,
  input logic [7:0] o_pad_input_en,
  input logic [7:0] o_pad_pullup_en,
  input logic [7:0] o_pullup_resistor_select,
  input logic o_pad4_ground_switch_enable
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  // Address of the read under way
  logic [11:0] ra_r;
  // Pads whose function inputs show any activity
  logic [7:0] any_in;
  always @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst)
      ra_r <= 12'h000;
    else if (i_axi_arvalid && o_axi_arready && i_clk_en)
      ra_r <= i_axi_araddr;
  for (genvar k = 0; k < 8; k++)
    assign any_in[k] = |o_pad_func_in[8*k+:8];
  // Good reads of each pad register
  wire ok = o_axi_rvalid && o_axi_rresp == 2'h0;
  wire rd4 = ok && ra_r[11:2] == 10'h001;
  wire rd8 = ok && ra_r[11:2] == 10'h002;
  chk_read_one: assert property
    (i_axi_arvalid && o_axi_arready && i_clk_en |=> o_axi_rvalid)
    else $error("read answer late");
  chk_rsvd_low: assert property
    (rd4 |-> o_axi_rdata[31:30] == 2'h0 && !o_axi_rdata[6])
    else $error("reserved bits set in group 4-7");
  chk_rsvd_high: assert property
    (rd8 |-> o_axi_rdata[31:30] == 2'h0 && o_axi_rdata[23:22] == 2'h0)
    else $error("reserved bits set in group 8-11");
  chk_drive_copy: assert property
    (rd4 |-> {o_axi_rdata[26], o_axi_rdata[18], o_axi_rdata[10],
      o_axi_rdata[2]} == o_pad_drive_high[3:0])
    else $error("drive outputs differ");
  chk_inen_copy: assert property
    (rd8 |-> {o_axi_rdata[25], o_axi_rdata[17], o_axi_rdata[9],
      o_axi_rdata[1]} == o_pad_input_en[7:4])
    else $error("input enables differ");
  chk_pull_copy: assert property
    (rd4 |-> {o_axi_rdata[24], o_axi_rdata[16], o_axi_rdata[8],
      o_axi_rdata[0]} == o_pad_pullup_en[3:0])
    else $error("pull-up enables differ");
  chk_rsel_copy: assert property
    (rd8 |-> {o_axi_rdata[15:14], o_axi_rdata[7:6]}
      == o_pullup_resistor_select[7:4])
    else $error("resistor codes differ");
  chk_gnd_copy: assert property
    (rd4 |-> o_axi_rdata[7] == o_pad4_ground_switch_enable)
    else $error("ground switch differs");
  chk_in_gated: assert property
    ((any_in & ~o_pad_input_en) == 8'h00)
    else $error("input routed while disabled");
endmodule // pcm_pad_config_asserts
bind pcm_pad_config pcm_pad_config_asserts chk (.*);

// [test/pcm_pad_config_tb.sv]
// Self-checking bench for the pad configuration block
`timescale 1ns/1ns
`include "pcm_consts.vh"
module pcm_pad_config_tb;
  // Design inputs
  logic i_clk_sys = 0, i_sys_rst = 1, i_clk_en = 1;
  logic [11:0] i_axi_awaddr = 0, i_axi_araddr = 0;
  logic [31:0] i_axi_wdata = 0;
  logic [3:0] i_axi_wstrb = 0;
  logic i_axi_awvalid = 0, i_axi_wvalid = 0, i_axi_arvalid = 0;
  logic i_axi_bready = 1, i_axi_rready = 1;
  logic [63:0] i_pad_func_out = 0, i_pad_func_oe = 0;
  logic [7:0] i_pad_in = 0;
  // Design outputs
  wire o_axi_awready, o_axi_wready, o_axi_bvalid;
  wire o_axi_arready, o_axi_rvalid, o_pad4_ground_switch_enable;
  wire [1:0] o_axi_bresp, o_axi_rresp;
  wire [31:0] o_axi_rdata;
  wire [63:0] o_pad_func_in;
  wire [7:0] o_pad_out, o_pad_oe, o_pad_drive_high, o_pad_input_en;
  wire [7:0] o_pad_pullup_en, o_pullup_resistor_select;
  // Counters, expected register images, random state
  int n_errors = 0, cmp_count = 0, cyc = 0;
  logic [31:0] g4 = `PCM_RST_GROUP_4_7, g8 = `PCM_RST_GROUP_8_11;
  logic [31:0] seed = 32'he268_bd4d;
  pcm_pad_config dut (.*);
  always #50 i_clk_sys = ~i_clk_sys;
  // Xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected config slot of pad p (pad 4 is p = 0)
  function automatic logic [7:0] slot(int p);
    return p < 4 ? g4[8*p+:8] : g8[8*p-32+:8];
  endfunction
  task summarize;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task ck(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Write one word, both halves offered together
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
    i_axi_awaddr <= a;
    i_axi_wdata <= d;
    i_axi_wstrb <= s;
    i_axi_awvalid <= 1;
    i_axi_wvalid <= 1;
    do
    begin
      @(posedge i_clk_sys);
      if (i_axi_awvalid && o_axi_awready) i_axi_awvalid <= 0;
      if (i_axi_wvalid && o_axi_wready) i_axi_wvalid <= 0;
    end while (!o_axi_bvalid);
    ck(o_axi_bresp, e);
  endtask
  // Read one word and compare data and response
  task rdc(input [11:0] a, input [31:0] ed, input [1:0] er);
    i_axi_araddr <= a;
    i_axi_arvalid <= 1;
    do
    begin
      @(posedge i_clk_sys);
      if (i_axi_arvalid && o_axi_arready) i_axi_arvalid <= 0;
    end while (!o_axi_rvalid);
    ck(o_axi_rdata, ed);
    ck(o_axi_rresp, er);
  endtask
  // Compare every pad output with the expected config
  task pads;
    logic [63:0] fi;
    logic [7:0] po, pe, dr, ie, pu, b;
    logic [2:0] s;
    for (int p = 0; p < 8; p++)
    begin
      b = slot(p);
      s = b[5:3];
      {dr[p], ie[p], pu[p]} = b[2:0];
      po[p] = i_pad_func_out[8*p+s];
      pe[p] = i_pad_func_oe[8*p+s];
      fi[8*p+:8] = b[1] ? {7'h0, i_pad_in[p]} << s : 8'h00;
      // Reserved code on pad 5 routes nothing
      if (p == 1 && s == 3'h5) {po[p], pe[p], fi[15:8]} = 10'h0;
    end
    ck({o_pad_drive_high, o_pad_input_en, o_pad_pullup_en},
       {dr, ie, pu});
    ck(o_pullup_resistor_select,
       {g8[15:14], g8[7:6], g4[23:22], g4[15:14]});
    ck(o_pad4_ground_switch_enable, g4[7]);
    ck(o_pad_out, po);
    ck(o_pad_oe, pe);
    ck(o_pad_func_in, fi);
  endtask
  // Cut a hang short
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      summarize;
    end
  end
  initial
  begin
    logic [31:0] d, m;
    logic [3:0] s;
    logic [11:0] a;
    logic [7:0] fo;
    repeat (20) @(posedge i_clk_sys);
    i_sys_rst <= 0;
    @(posedge i_clk_sys);
    pads;
    rdc(12'h004, `PCM_RST_GROUP_4_7, `PCM_RESP_OKAY);
    rdc(12'h008, `PCM_RST_GROUP_8_11, `PCM_RESP_OKAY);
    // Locked write and unmapped place
    wr(12'h004, 32'hFFFF_FFFF, 4'hF, `PCM_RESP_OKAY);
    rdc(12'h004, g4, `PCM_RESP_OKAY);
    wr(12'h0F0, 32'h1234_5678, 4'hF, `PCM_RESP_SLVERR);
    rdc(12'h0F0, 32'h0000_0000, `PCM_RESP_SLVERR);
    wr(12'h060, `PCM_KEY_DEFAULT, 4'hF, `PCM_RESP_OKAY);
    rdc(12'h060, 32'h0000_0001, `PCM_RESP_OKAY);
    // Every selector code on every pad, then random words and strobes
    for (int i = 0; i < 48; i++)
    begin
      d = rnd();
      s = i < 16 ? 4'hF : 4'(rnd());
      a = i[0] ? 12'h008 : 12'h004;
      if (i < 16)
        for (int p = 0; p < 4; p++)
          d[8*p+1+:5] = {i[3:1], 2'h1};
      i_pad_func_out <= {rnd(), rnd()};
      i_pad_func_oe <= {rnd(), rnd()};
      i_pad_in <= 8'(rnd());
      wr(a, d, s, `PCM_RESP_OKAY);
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      if (i[0])
        g8 = (g8 & ~m | d & m) & `PCM_WMASK_GROUP_8_11;
      else
        g4 = (g4 & ~m | d & m) & `PCM_WMASK_GROUP_4_7;
      rdc(a, i[0] ? g8 : g4, `PCM_RESP_OKAY);
      pads;
    end
    // Wrong key locks again
    wr(12'h060, 32'h0000_0000, 4'hF, `PCM_RESP_OKAY);
    rdc(12'h060, 32'h0000_0000, `PCM_RESP_OKAY);
    wr(12'h008, ~g8, 4'hF, `PCM_RESP_OKAY);
    rdc(12'h008, g8, `PCM_RESP_OKAY);
    // Clock enable low holds the pads while their inputs change
    fo = o_pad_out;
    i_clk_en <= 0;
    i_pad_func_out <= ~i_pad_func_out;
    repeat (3) @(posedge i_clk_sys);
    ck(o_pad_out, fo);
    i_clk_en <= 1;
    repeat (2) @(posedge i_clk_sys);
    pads;
    // Reset in mid-run restores the fields and locks the key
    i_sys_rst <= 1;
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 0;
    g4 = `PCM_RST_GROUP_4_7;
    g8 = `PCM_RST_GROUP_8_11;
    @(posedge i_clk_sys);
    rdc(12'h004, g4, `PCM_RESP_OKAY);
    rdc(12'h008, g8, `PCM_RESP_OKAY);
    rdc(12'h060, 32'h0000_0000, `PCM_RESP_OKAY);
    pads;
    summarize;
  end
endmodule // pcm_pad_config_tb
